// File: hw/lcdr_addr_step.sv
// Next-address calculation for the display RAM column and row counters.
`timescale 1ns/1ps
module lcdr_addr_step
    import lcdr_pkg::*;
(
    // Present counters.
    input wire logic [3:0] col,
    input wire logic [6:0] row,
    // Stepping selection.
    input wire logic step_col,
    input wire logic step_row,
    input wire logic mirrored,
    // Next counters.
    output logic [3:0] col_next,
    output logic [6:0] row_next
);

    // ****************************************************************
    // Stepping logic.
    // ****************************************************************

    // Column end that closes one sweep in the current direction.
    logic [3:0] col_end;

    // Computes the next column and row for one access.
    always_comb begin
        col_end = mirrored ? 4'h0 : COL_LAST;
        col_next = col;
        row_next = row;
        if (step_col) begin
            // Wraps in both directions through the four-bit width.
            col_next = mirrored ? col - 4'h1 : col + 4'h1;
        end
        if (step_row && (!step_col || col == col_end)) begin
            // Row wraps from 3FH back to 00H regardless of order.
            row_next = (row == ROW_GRAPHIC_LAST) ? 7'h00 : row + 7'h01;
        end
    end

endmodule // lcdr_addr_step

// File: hw/lcdr_ctrl_regs.sv
// Command register bank, RAM address stepping and display control outputs.
`timescale 1ns/1ps
module lcdr_ctrl_regs
    import lcdr_pkg::*;
#(
    parameter int LINE_COUNT = LINE_COUNT_DEFAULT
)
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Host parallel bus.
    input wire logic CHIP_SELECT_N,
    input wire logic REGISTER_SELECT,
    input wire logic WRITE_STROBE_N,
    input wire logic READ_STROBE_N,
    input wire logic EXTENDED_FLAG,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    // Display RAM port.
    input wire logic [7:0] RAM_RDATA,
    output logic RAM_WE,
    output logic RAM_RE,
    output logic [3:0] RAM_COL,
    output logic [6:0] RAM_ROW,
    output logic [7:0] RAM_WDATA,
    // Display timing and pixel path.
    input wire logic LINE_TICK,
    input wire logic PIXEL_DATA,
    output logic [5:0] ROW_ADDR,
    output logic [5:0] COM_INDEX,
    output logic ALT_SIGNAL,
    output logic DOT_LIT,
    output logic SEGMENT_GROUND,
    // Control settings seen by the drivers.
    output logic [5:0] START_LINE,
    output logic [5:0] ALT_COUNT,
    output logic GRAPHIC_ON,
    output logic FORCE_ALL_LIT,
    output logic SEGMENT_ENABLE,
    output logic SCAN_REVERSE,
    output logic SEGMENT_INTERNAL_SOURCE,
    output logic SEGMENT_EXTERNAL_SOURCE,
    output logic INVERT_DISPLAY,
    output logic NLINE_ALTERNATION_ENABLE,
    output logic WRITE_SWAP,
    output logic SEGMENT_ORDER
);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************

    // The line counter is six bits wide, so more than 64 lines cannot be served.
    if (LINE_COUNT < 2 || LINE_COUNT > 64) begin : g_bad_lines
        $error("LINE_COUNT must lie between 2 and 64");
    end

    localparam logic [5:0] LINE_LAST = 6'(LINE_COUNT - 1);

    // ****************************************************************
    // State.
    // ****************************************************************

    // Whole module state held in one record.
    typedef struct packed {
        logic wr_prev;          // Write strobe seen active last cycle.
        logic rd_prev;          // Read strobe seen active last cycle.
        logic [3:0] sl_lo;      // Start line low nibble.
        logic [1:0] sl_hi;      // Start line high part.
        logic [3:0] ac_lo;      // Alternation count low nibble.
        logic [1:0] ac_hi;      // Alternation count high part.
        logic [3:0] dc1;        // Display control one.
        logic [1:0] seg_src;    // Segment source bits.
        logic [3:0] dc2;        // Display control two.
        logic [2:0] step_ctl;   // Address step control.
        logic [3:0] col;        // Host column counter.
        logic [6:0] row;        // Host row counter.
        logic [3:0] rd_addr;    // Register readback selector.
        logic [7:0] dout;       // Data returned to the host.
        logic doe;              // Host data bus drive enable.
        logic ram_we;           // RAM write pulse.
        logic ram_re;           // RAM read pulse.
        logic [3:0] ram_col;    // Internal RAM column.
        logic [6:0] ram_row;    // Internal RAM row.
        logic [7:0] ram_wdata;  // Internal RAM write byte.
        logic [5:0] line;       // Current scan line within the frame.
        logic [5:0] alt_cnt;    // Lines since last alternation.
        logic alt_sig;          // Alternating drive signal.
        logic [5:0] row_addr;   // RAM line shown on the current common.
        logic [5:0] com_idx;    // Common output being driven.
        logic dot_lit;          // Lit state of the current dot.
        logic seg_gnd;          // Segment pins held at ground.
    } lcdr_state_t;

    lcdr_state_t state_q;
    lcdr_state_t state_d;

    // Combined settings read by several processes.
    logic [5:0] start_line;
    logic [5:0] alt_count;
    logic mirrored;
    assign start_line = {state_q.sl_hi, state_q.sl_lo};
    assign alt_count = {state_q.ac_hi, state_q.ac_lo};
    assign mirrored = state_q.dc2[DC2_SEGMENT_ORDER];

    // ****************************************************************
    // Address stepping.
    // ****************************************************************

    logic [3:0] col_next;
    logic [6:0] row_next;
    logic step_col;
    logic step_row;

    lcdr_addr_step u_step (
        .col(state_q.col),
        .row(state_q.row),
        .step_col(step_col),
        .step_row(step_row),
        .mirrored(mirrored),
        .col_next(col_next),
        .row_next(row_next)
    );

    // ****************************************************************
    // Helpers.
    // ****************************************************************

    // Reverses the bit order of a byte.
    function automatic logic [7:0] flip_byte(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************

    // Host access events, RAM mapping, register writes and scan timing.
    always_comb begin
        logic wr_act;
        logic rd_act;
        logic wr_ev;
        logic rd_ev;
        logic graphic;
        logic access_steps;
        logic [3:0] cmd;
        logic [3:0] arg;
        logic [5:0] line_next;
        wr_act = !CHIP_SELECT_N && !WRITE_STROBE_N;
        rd_act = !CHIP_SELECT_N && !READ_STROBE_N;
        wr_ev = wr_act && !state_q.wr_prev;
        rd_ev = rd_act && !state_q.rd_prev;
        graphic = state_q.row < ROW_SEGMENT_FIRST;
        cmd = DATA_IN[7:4];
        arg = DATA_IN[3:0];
        line_next = state_q.line;
        state_d = state_q;
        state_d.wr_prev = wr_act;
        state_d.rd_prev = rd_act;
        state_d.ram_we = 1'b0;
        state_d.ram_re = 1'b0;
        state_d.doe = rd_act;
        step_col = 1'b0;
        step_row = 1'b0;

        // Stepping applies to graphic RAM only; read steps only when mode is clear.
        access_steps = graphic && !REGISTER_SELECT
                       && (wr_ev || (rd_ev && !state_q.step_ctl[STEP_MODE]));
        if (access_steps) begin
            // Neither bit set means no stepping at all.
            step_col = state_q.step_ctl[STEP_COL];
            step_row = state_q.step_ctl[STEP_ROW];
        end

        // RAM access: register select low reaches display RAM.
        if (!REGISTER_SELECT && (wr_ev || rd_ev)) begin
            // Mirrored order maps column n to 0FH minus n for both RAM areas.
            state_d.ram_col = mirrored ? COL_LAST - state_q.col : state_q.col;
            state_d.ram_row = state_q.row;
            state_d.ram_we = wr_ev;
            state_d.ram_re = rd_ev;
            if (graphic) begin
                // Swap and mirrored order each reverse the byte; both cancel.
                state_d.ram_wdata = (state_q.dc2[DC2_WRITE_SWAP] ^ mirrored) ? flip_byte(DATA_IN) : DATA_IN;
            end else begin
                // Segment RAM keeps its bit order in every mode.
                state_d.ram_wdata = DATA_IN;
            end
            state_d.col = col_next;
            state_d.row = row_next;
        end

        // RAM read data returns one cycle after the read pulse.
        if (state_q.ram_re) begin
            if (state_q.ram_row < ROW_SEGMENT_FIRST && mirrored) begin
                state_d.dout = flip_byte(RAM_RDATA);
            end else begin
                state_d.dout = RAM_RDATA;
            end
        end

        // Register writes with register select high.
        if (REGISTER_SELECT && wr_ev) begin
            unique case (cmd)
                CMD_COL_ADDR: begin
                    state_d.col = arg;
                end
                CMD_ROW_LOW: begin
                    state_d.row[3:0] = arg;
                end
                CMD_ROW_HIGH: begin
                    state_d.row[6:4] = arg[2:0];
                end
                CMD_START_LOW: begin
                    state_d.sl_lo = arg;
                end
                CMD_START_HIGH: begin
                    state_d.sl_hi = arg[1:0];
                end
                CMD_ALT_LOW: begin
                    state_d.ac_lo = arg;
                end
                CMD_ALT_HIGH: begin
                    state_d.ac_hi = arg[1:0];
                end
                CMD_DISP_ONE: begin
                    if (EXTENDED_FLAG) begin
                        // Extended page holds the segment source bits.
                        state_d.seg_src = arg[1:0];
                    end else begin
                        state_d.dc1 = arg;
                    end
                end
                CMD_DISP_TWO: begin
                    state_d.dc2 = arg;
                end
                CMD_STEP_CTL: begin
                    // Counters are left as they are; the host reloads them.
                    state_d.step_ctl = arg[2:0];
                end
                CMD_READ_ADDR: begin
                    state_d.rd_addr = arg;
                end
                default: begin
                    // Codes outside this bank are ignored here.
                end
            endcase
        end

        // Register readback through the selected read address.
        if (REGISTER_SELECT && rd_ev) begin
            unique case (state_q.rd_addr)
                CMD_COL_ADDR: state_d.dout = {4'h0, state_q.col};
                CMD_ROW_LOW: state_d.dout = {4'h0, state_q.row[3:0]};
                CMD_ROW_HIGH: state_d.dout = {5'h00, state_q.row[6:4]};
                CMD_START_LOW: state_d.dout = {4'h0, state_q.sl_lo};
                CMD_START_HIGH: state_d.dout = {6'h00, state_q.sl_hi};
                CMD_ALT_LOW: state_d.dout = {4'h0, state_q.ac_lo};
                CMD_ALT_HIGH: state_d.dout = {6'h00, state_q.ac_hi};
                CMD_DISP_ONE: state_d.dout = EXTENDED_FLAG ? {6'h00, state_q.seg_src} : {4'h0, state_q.dc1};
                CMD_DISP_TWO: state_d.dout = {4'h0, state_q.dc2};
                CMD_STEP_CTL: state_d.dout = {5'h00, state_q.step_ctl};
                CMD_READ_ADDR: state_d.dout = {4'h0, state_q.rd_addr};
                default: state_d.dout = 8'h00;
            endcase
        end

        // Scan timing advances on each line tick.
        if (LINE_TICK) begin
            line_next = (state_q.line == LINE_LAST) ? 6'h00 : state_q.line + 6'h01;
            state_d.line = line_next;
            if (state_q.dc2[DC2_NLINE_ENABLE]) begin
                // Code k gives an inversion every k plus one lines.
                if (state_q.alt_cnt >= alt_count) begin
                    state_d.alt_cnt = 6'h00;
                    state_d.alt_sig = !state_q.alt_sig;
                end else begin
                    state_d.alt_cnt = state_q.alt_cnt + 6'h01;
                end
            end else begin
                // Without n-line drive the signal flips once per frame.
                state_d.alt_cnt = 6'h00;
                if (state_q.line == LINE_LAST) begin
                    state_d.alt_sig = !state_q.alt_sig;
                end
            end
        end

        // Shown RAM line climbs from the start line on the first common.
        state_d.row_addr = start_line + state_q.line;
        // Scan direction runs commons forward or backward.
        state_d.com_idx = state_q.dc1[DC1_SCAN_REVERSE] ? LINE_LAST - state_q.line : state_q.line;

        // All-on outranks reverse; off blanks the graphic area.
        state_d.dot_lit = state_q.dc1[DC1_GRAPHIC_ON]
                          && (state_q.dc1[DC1_FORCE_ALL_LIT] || (PIXEL_DATA ^ state_q.dc2[DC2_INVERT_DISPLAY]));
        // Segment display off holds its pins at ground.
        state_d.seg_gnd = !state_q.dc1[DC1_SEGMENT_ENABLE];
    end

    // ****************************************************************
    // State register.
    // ****************************************************************

    // Registers the whole state; every control field clears at reset except the read address, which loads 0CH.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_q <= '0;
            state_q.rd_addr <= RESET_READ_ADDR;
            state_q.dc1 <= RESET_NIBBLE;
            state_q.dc2 <= RESET_NIBBLE;
            state_q.seg_gnd <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Outputs, each taken straight from the state register.
    // ****************************************************************

    assign DATA_OUT = state_q.dout;
    assign DATA_OE = state_q.doe;
    assign RAM_WE = state_q.ram_we;
    assign RAM_RE = state_q.ram_re;
    assign RAM_COL = state_q.ram_col;
    assign RAM_ROW = state_q.ram_row;
    assign RAM_WDATA = state_q.ram_wdata;
    assign ROW_ADDR = state_q.row_addr;
    assign COM_INDEX = state_q.com_idx;
    assign ALT_SIGNAL = state_q.alt_sig;
    assign DOT_LIT = state_q.dot_lit;
    assign SEGMENT_GROUND = state_q.seg_gnd;
    assign START_LINE = {state_q.sl_hi, state_q.sl_lo};
    assign ALT_COUNT = {state_q.ac_hi, state_q.ac_lo};
    assign GRAPHIC_ON = state_q.dc1[DC1_GRAPHIC_ON];
    assign FORCE_ALL_LIT = state_q.dc1[DC1_FORCE_ALL_LIT];
    assign SEGMENT_ENABLE = state_q.dc1[DC1_SEGMENT_ENABLE];
    assign SCAN_REVERSE = state_q.dc1[DC1_SCAN_REVERSE];
    assign SEGMENT_INTERNAL_SOURCE = state_q.seg_src[SRC_INTERNAL];
    assign SEGMENT_EXTERNAL_SOURCE = state_q.seg_src[SRC_EXTERNAL];
    assign INVERT_DISPLAY = state_q.dc2[DC2_INVERT_DISPLAY];
    assign NLINE_ALTERNATION_ENABLE = state_q.dc2[DC2_NLINE_ENABLE];
    assign WRITE_SWAP = state_q.dc2[DC2_WRITE_SWAP];
    assign SEGMENT_ORDER = state_q.dc2[DC2_SEGMENT_ORDER];

endmodule // lcdr_ctrl_regs

// File: hw/lcdr_pkg.sv
// Constants shared by the LCD display command register bank.
// How it works
// - Six-bit start line from two writes.
// - Rows scan upward from start line.
// - Six-bit alternation count, period code plus one.
// - Alternation every n lines or per frame.
// - Control one holds on, all-on, segment, scan.
// - All-on lights every dot, beats reverse.
// - Segment off drives segment pins to ground.
// - Scan bit picks forward or backward commons.
// - Control two holds reverse, n-line, swap, order.
// - Segment order mirrors column and bit order.
// - Segment RAM mirrors column, keeps bit order.
// - Swap bit-reverses bytes written to graphic RAM.
// - Reverse bit swaps which RAM level lights.
// - Step control holds mode, row, column bits.
// - Mode picks stepping on all accesses or writes.
// - Row and column bits select stepping pattern.
// - Column steps up, or down when mirrored.
// - Row steps cyclically 00H to 3FH.
// - Cooperative mode bumps row at column 0FH, or 00H when mirrored.
package lcdr_pkg;

    // ****************************************************************
    // Command codes carried in the upper nibble of a register write.
    // ****************************************************************
    localparam logic [3:0] CMD_COL_ADDR = 4'h0;
    localparam logic [3:0] CMD_ROW_LOW = 4'h2;
    localparam logic [3:0] CMD_ROW_HIGH = 4'h3;
    localparam logic [3:0] CMD_START_LOW = 4'h4;
    localparam logic [3:0] CMD_START_HIGH = 4'h5;
    localparam logic [3:0] CMD_ALT_LOW = 4'h6;
    localparam logic [3:0] CMD_ALT_HIGH = 4'h7;
    localparam logic [3:0] CMD_DISP_ONE = 4'h8;
    localparam logic [3:0] CMD_DISP_TWO = 4'h9;
    localparam logic [3:0] CMD_STEP_CTL = 4'hA;
    localparam logic [3:0] CMD_READ_ADDR = 4'hC;

    // ****************************************************************
    // Field positions inside the control registers.
    // ****************************************************************
    localparam int DC1_GRAPHIC_ON = 0;
    localparam int DC1_FORCE_ALL_LIT = 1;
    localparam int DC1_SEGMENT_ENABLE = 2;
    localparam int DC1_SCAN_REVERSE = 3;
    localparam int SRC_INTERNAL = 0;
    localparam int SRC_EXTERNAL = 1;
    localparam int DC2_SEGMENT_ORDER = 0;
    localparam int DC2_WRITE_SWAP = 1;
    localparam int DC2_NLINE_ENABLE = 2;
    localparam int DC2_INVERT_DISPLAY = 3;
    localparam int STEP_COL = 0;
    localparam int STEP_ROW = 1;
    localparam int STEP_MODE = 2;

    // ****************************************************************
    // Reset values and address limits.
    // ****************************************************************
    localparam logic [3:0] RESET_NIBBLE = 4'h0;
    localparam logic [3:0] RESET_READ_ADDR = 4'hC;
    localparam logic [3:0] COL_LAST = 4'hF;
    localparam logic [6:0] ROW_GRAPHIC_LAST = 7'h3F;
    localparam logic [6:0] ROW_SEGMENT_FIRST = 7'h40;
    localparam int LINE_COUNT_DEFAULT = 64;

endpackage : lcdr_pkg

// File: testbench/lcdr_ctrl_regs_asserts.sv
// Port-level assertions for the command register bank.
`timescale 1ns/1ps
module lcdr_ctrl_regs_asserts #(
    parameter int LINE_COUNT = 64
) (
    // Clock, reset and host bus.
    input wire logic CLK_SYS, RST, CHIP_SELECT_N, REGISTER_SELECT, WRITE_STROBE_N, EXTENDED_FLAG,
    input wire logic [7:0] DATA_IN,
    // RAM write port and pixel path.
    input wire logic RAM_WE, PIXEL_DATA, DOT_LIT, SEGMENT_GROUND, LINE_TICK, ALT_SIGNAL,
    input wire logic [6:0] RAM_ROW,
    input wire logic [7:0] RAM_WDATA,
    input wire logic [5:0] ROW_ADDR, COM_INDEX, START_LINE, ALT_COUNT,
    // Control levels.
    input wire logic GRAPHIC_ON, FORCE_ALL_LIT, SEGMENT_ENABLE, SCAN_REVERSE,
    input wire logic INVERT_DISPLAY, NLINE_ALTERNATION_ENABLE, WRITE_SWAP, SEGMENT_ORDER
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic wr_prev_q; // Write strobe active last edge.
    logic [7:0] din_rev; // Write byte in mirrored bit order.
    logic [5:0] line_no; // Scan line implied by the shown row.
    logic cmd_wr; // A new command register write is taken this edge.
    // A held strobe is one access only.
    always_ff @(posedge CLK_SYS) begin
        wr_prev_q <= RST ? 1'b0 : (!CHIP_SELECT_N && !WRITE_STROBE_N);
    end
    // Mirror the byte, recover the scan line and decode a fresh command write.
    always_comb begin
        for (int i = 0; i < 8; i++) din_rev[i] = DATA_IN[7-i];
        line_no = ROW_ADDR - START_LINE;
        cmd_wr = REGISTER_SELECT && !CHIP_SELECT_N && !WRITE_STROBE_N && !wr_prev_q;
    end
    a_start_low_write: assert property (cmd_wr && DATA_IN[7:4] == 4'h4 |=> START_LINE[3:0] == $past(DATA_IN[3:0]))
        else $error("start low not stored");
    a_alt_high_write: assert property (cmd_wr && DATA_IN[7:4] == 4'h7 |=> ALT_COUNT[5:4] == $past(DATA_IN[1:0]))
        else $error("alt count high not stored");
    a_ctrl_one_write: assert property (cmd_wr && !EXTENDED_FLAG && DATA_IN[7:4] == 4'h8
        |=> {SCAN_REVERSE, SEGMENT_ENABLE, FORCE_ALL_LIT, GRAPHIC_ON} == $past(DATA_IN[3:0]))
        else $error("display control one not stored");
    a_ctrl_two_write: assert property (cmd_wr && DATA_IN[7:4] == 4'h9
        |=> {INVERT_DISPLAY, NLINE_ALTERNATION_ENABLE, WRITE_SWAP, SEGMENT_ORDER} == $past(DATA_IN[3:0]))
        else $error("display control two not stored");
    a_all_lit_wins: assert property ($past(GRAPHIC_ON && FORCE_ALL_LIT) |-> DOT_LIT)
        else $error("forced dot not lit");
    a_dot_polarity: assert property ($past(GRAPHIC_ON && !FORCE_ALL_LIT)
        |-> DOT_LIT == $past(PIXEL_DATA ^ INVERT_DISPLAY))
        else $error("dot level wrong");
    a_display_off: assert property (!$past(GRAPHIC_ON) |-> !DOT_LIT)
        else $error("dot lit while display off");
    a_segment_ground: assert property (!SEGMENT_ENABLE && !$past(SEGMENT_ENABLE) |-> SEGMENT_GROUND)
        else $error("segment pins not grounded");
    a_write_swap: assert property ($rose(RAM_WE) && RAM_ROW < 7'h40
        |-> RAM_WDATA == $past((WRITE_SWAP ^ SEGMENT_ORDER) ? din_rev : DATA_IN))
        else $error("stored byte order wrong");
    a_scan_order: assert property ($stable(START_LINE) && $stable(SCAN_REVERSE)
        |-> COM_INDEX == (SCAN_REVERSE ? 6'(LINE_COUNT - 1) - line_no : line_no))
        else $error("scan order wrong");
    a_alt_on_tick: assert property ($changed(ALT_SIGNAL) |-> $past(LINE_TICK))
        else $error("alternation flipped without a line tick");
endmodule // lcdr_ctrl_regs_asserts
bind lcdr_ctrl_regs lcdr_ctrl_regs_asserts #(.LINE_COUNT(LINE_COUNT)) u_chk (.*);

// File: testbench/lcdr_host_model.sv
// Host processor model on the parallel bus.
`timescale 1ns/1ps
module lcdr_host_model (
    // Clock and returned read byte.
    input wire logic clk,
    input wire logic [7:0] dout,
    // Bus strobes and write byte.
    output logic cs_n,
    output logic rs,
    output logic wr_n,
    output logic rd_n,
    output logic [7:0] din
);
    // The bus idles deselected with both strobes high.
    initial {cs_n, rs, wr_n, rd_n, din} = 12'hB00;
    // One access: strobe held for lag edges, answer taken, then released.
    task automatic acc(input logic sel, input logic wr, input logic [7:0] d, input int lag, output logic [7:0] q);
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        rs = sel;
        din = d;
        wr_n = !wr;
        rd_n = wr;
        repeat (lag) @(posedge clk);
        #1;
        q = dout;
        {cs_n, wr_n, rd_n} = 3'b111;
        din = ~d; // Released bus shows no stale byte.
    endtask
endmodule // lcdr_host_model

// File: testbench/tb_top.sv
// Random self-checking bench for the command registers.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, ext = 1'b0, tick = 1'b0, pix = 1'b0;
    logic cs_n, rs, wr_n, rd_n, oe, we, re, alt, dot, sg, gon, fal, sen, scr, sin, sex, inv, nle, wsw, sor;
    logic [7:0] din, dout, rram = 8'h00, wdat, q;
    logic [3:0] col;
    logic [6:0] row;
    logic [5:0] radr, com, sl, ac;
    logic [7:0] val [16];
    int error_cnt = 0, checked = 0;
    // Clock and a watchdog against a hung run.
    initial forever #5 clk = ~clk;
    initial begin
        #500000;
        error_cnt++;
        print_verdict();
    end
    // Random scan ticks, pixels and RAM data.
    always @(posedge clk) if (!rst) begin
        #1;
        {tick, pix, rram} = 10'($urandom);
    end
    lcdr_host_model host (.clk(clk), .dout(dout), .cs_n(cs_n), .rs(rs), .wr_n(wr_n), .rd_n(rd_n), .din(din));
    lcdr_ctrl_regs uut (.CLK_SYS(clk), .RST(rst), .CHIP_SELECT_N(cs_n), .REGISTER_SELECT(rs), .WRITE_STROBE_N(wr_n),
        .READ_STROBE_N(rd_n), .EXTENDED_FLAG(ext), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .RAM_RDATA(rram),
        .RAM_WE(we), .RAM_RE(re), .RAM_COL(col), .RAM_ROW(row), .RAM_WDATA(wdat), .LINE_TICK(tick),
        .PIXEL_DATA(pix), .ROW_ADDR(radr), .COM_INDEX(com), .ALT_SIGNAL(alt), .DOT_LIT(dot), .SEGMENT_GROUND(sg),
        .START_LINE(sl), .ALT_COUNT(ac), .GRAPHIC_ON(gon), .FORCE_ALL_LIT(fal), .SEGMENT_ENABLE(sen),
        .SCAN_REVERSE(scr), .SEGMENT_INTERNAL_SOURCE(sin), .SEGMENT_EXTERNAL_SOURCE(sex), .INVERT_DISPLAY(inv),
        .NLINE_ALTERNATION_ENABLE(nle), .WRITE_SWAP(wsw), .SEGMENT_ORDER(sor));
    // Count one comparison and report a mismatch.
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // Print the verdict and stop.
    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // A write, and a register read via the read address.
    task automatic wr(input logic sel, input logic [7:0] d);
        host.acc(sel, 1'b1, d, 1, q);
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        wr(1'b1, {4'hC, a});
        host.acc(1'b1, 1'b0, 8'hFF, 3, v);
    endtask
    // Byte in mirrored bit order when f is set.
    function automatic logic [7:0] flip(input logic [7:0] d, input logic f);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = d[f ? 7 - i : i];
        return r;
    endfunction
    // Check the RAM write that the last access launched.
    task automatic chk_we(input logic [3:0] c, input logic [6:0] r, input logic [7:0] d);
        cmp(8'(we), 8'h01, "ram write strobe");
        cmp(8'(col), 8'(c), "ram column");
        cmp(8'(row), 8'(r), "ram row");
        cmp(wdat, d, "ram write byte");
    endtask
    initial begin
        logic [7:0] v, got;
        logic [2:0] m;
        logic o, s;
        int hx, hr, i, n;
        void'($urandom(32'hC2C58D5C));
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        // ****
        // Reset values, random writes and readback of register codes 4 to 11.
        // ****
        for (i = 4; i < 12; i++) begin
            rd_reg(i[3:0], got);
            cmp(got, 8'h00, "reset value");
            v = 8'($urandom);
            // Readable width: two bits at 5 and 7, three at A, none at B.
            val[i] = v & (i == 5 || i == 7 ? 8'h03 : i == 10 ? 8'h07 : i == 11 ? 8'h00 : 8'h0F);
            wr(1'b1, {i[3:0], v[3:0]});
            rd_reg(i[3:0], got);
            cmp(got, val[i], "readback");
        end
        cmp(8'(sl), 8'({val[5][1:0], val[4][3:0]}), "start line");
        cmp(8'(ac), 8'({val[7][1:0], val[6][3:0]}), "alternation count");
        // Segment source bits via the extended path.
        ext = 1'b1;
        wr(1'b1, 8'h82);
        ext = 1'b0;
        cmp({2'b00, sex, sin, scr, sen, fal, gon}, {4'h2, val[8][3:0]}, "segment source");
        // Every display control pattern.
        for (i = 0; i < 16; i++) begin
            wr(1'b1, {4'h8, i[3:0]});
            wr(1'b1, {4'h9, i[3:0]});
            repeat (6) @(posedge clk);
            cmp({scr, sen, fal, gon, inv, nle, wsw, sor}, {i[3:0], i[3:0]}, "control levels");
            cmp(8'(sg), 8'(!i[2]), "segment ground");
        end
        // ****
        // Address stepping in every mode, both column orders, row wrap.
        // ****
        for (i = 0; i < 16; i++) begin
            m = i[2:0];
            o = i[3];
            s = 1'($urandom);
            hx = o ? 1 : 14;
            hr = 63;
            wr(1'b1, {4'h9, 2'b00, s, o});
            wr(1'b1, {5'b10100, m});
            wr(1'b1, {4'h0, hx[3:0]});
            wr(1'b1, 8'h2F);
            wr(1'b1, 8'h33);
            for (n = 0; n < 4; n++) begin
                v = 8'($urandom);
                host.acc(1'b0, n != 1, v, n == 1 ? 3 : 1, got);
                if (n != 1) chk_we(o ? 4'(15 - hx) : hx[3:0], hr[6:0], flip(v, s ^ o));
                if (n != 1 || !m[2]) begin
                    if (m[1] && (!m[0] || hx == (o ? 0 : 15))) hr = (hr + 1) % 64;
                    if (m[0]) hx = o ? (hx + 15) % 16 : (hx + 1) % 16;
                end
            end
        end
        // Segment RAM: column mirrored, bit order kept.
        for (n = 0; n < 5; n++) wr(1'b1, 8'(40'hA0930F2034 >> (32 - 8 * n)));
        v = 8'($urandom);
        wr(1'b0, v);
        chk_we(4'h0, 7'h40, v);
        print_verdict();
    end
endmodule // tb_top
